// ==== design/dcs_core.sv ====
// Purpose: Register bank holding output code, trims, configuration, software reset and status.
// Assumes: Host drives sclk, frame_sel_n and sdin; monitor inputs are asynchronous levels.
// Notes: Frames cross from sclk to mclk by a toggle and are decoded here.
// Contract
// - Output code 16 bits, resets zero, readable.
// - Gain trim word 16 bits, resets zero.
// - Zero trim word signed, resets zero.
// - Address 0x56 decodes as the reset register.
// - Reset bit one restores all defaults.
// - Reset bit clears itself when done.
// - Reset register upper bits are ignored.
// - Status is read-only, upper bits zero.
// - Status bit 4 flags frame check fault.
// - Status bit 3 flags watchdog timeout.
// - Status bit 2 flags output load fault.
// - Status bit 1 shows ramp in progress.
// - Status bit 0 flags overtemperature.
// - Monitor continuously, set alarm on detection.
// - Alarm holds until resolved or reset.
// - Alarm reasserts if still present next cycle.
// - Narrow variant keeps bits 15..4, low zero.
// - Trim adjusts code when calibration enabled.
`timescale 1ns/1ps
`include "dcs_regs.svh"
module dcs_core #(
    parameter int RES_BITS = 16,
    parameter int SRST_CYC = `DCS_SRST_CYC,
    parameter int MON_CYC = `DCS_MON_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic frame_sel_n,
    input wire logic sdin,
    output logic sdo,
    input wire logic frame_check_src,
    input wire logic timeout_src,
    input wire logic output_load_src,
    input wire logic overtemp_src,
    input wire logic ramp_active_src,
    output dcs_pkg::dcs_word_t current_output_code,
    output logic user_trim_enable,
    output logic ramp_enable,
    output logic [3:0] ramp_rate_clock_select,
    output logic [2:0] ramp_step_select,
    output logic soft_reset_busy
);
    // Word mask for the narrower variant, applied on write and on read.
    // At full width the mask is all ones and the function passes the word through.
    function automatic dcs_pkg::dcs_word_t fit_word(input dcs_pkg::dcs_word_t w);
        dcs_pkg::dcs_word_t m;
        m = 16'hffff << (16 - RES_BITS);
        return w & m;
    endfunction

    // Link logic on the host clock and its crossing.
    dcs_link_if lnk ();

    dcs_link u_link (
        .sclk(sclk),
        .rst_n(rst_n),
        .frame_sel_n(frame_sel_n),
        .sdin(sdin),
        .sdo(sdo),
        .lnk(lnk.link)
    );

    logic [2:0] tgl_sync_r;
    logic [4:0] mon_s1_r;
    logic [4:0] mon_s2_r;

    // Toggle synchroniser; the third stage only serves the edge compare.
    // The frame word is not synchronised: it stands still from its toggle until the next frame ends.
    // That is why the host must keep the gap between frames.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tgl_sync_r <= 3'h0;
        else
            tgl_sync_r <= {tgl_sync_r[1:0], lnk.frame_tgl};
    end

    // Two-stage synchroniser for the monitor levels.
    // Only the second stage feeds the alarm and status logic.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mon_s1_r <= 5'h00;
            mon_s2_r <= 5'h00;
        end
        else
        begin
            mon_s1_r <= {frame_check_src, timeout_src, output_load_src, ramp_active_src, overtemp_src};
            mon_s2_r <= mon_s1_r;
        end
    end

    // A new frame is seen once per toggle edge and split into fields.
    wire frame_new = tgl_sync_r[2] ^ tgl_sync_r[1];
    wire [7:0] f_addr = lnk.frame_word[23:16];
    wire [15:0] f_data = lnk.frame_word[15:0];

    // Register state.
    // Data registers below return to their power-on values during software reset.
    dcs_pkg::dcs_state_t state_r;
    dcs_pkg::dcs_state_t state_nxt;
    logic [7:0] srst_cnt_r;
    logic [7:0] srst_cnt_nxt;
    logic srst_req_r;
    dcs_pkg::dcs_word_t code_r;
    dcs_pkg::dcs_word_t gain_r;
    dcs_pkg::dcs_word_t zero_r;
    logic [`DCS_CFG_USED-1:0] cfg_r;
    logic [4:0] alarm_r;
    logic [4:0] alarm_nxt;
    logic [15:0] mon_cnt_r;
    dcs_pkg::dcs_word_t rd_word_r;
    dcs_pkg::dcs_word_t rd_word_nxt;

    // Frames are only accepted while running.
    wire take = frame_new && (state_r == dcs_pkg::ST_RUN);

    // Address match of an accepted frame; all inputs are arguments so the wires follow them.
    function automatic logic frame_hits(input logic ok, input dcs_pkg::dcs_addr_t got,
                                        input dcs_pkg::dcs_addr_t want);
        return ok && (got == want);
    endfunction

    // Write strobes and the read request, one per decoded address.
    wire wr_code = frame_hits(take, f_addr, `DCS_ADDR_CODE);
    wire wr_gain = frame_hits(take, f_addr, `DCS_ADDR_GAIN);
    wire wr_zero = frame_hits(take, f_addr, `DCS_ADDR_ZERO);
    wire wr_cfg = frame_hits(take, f_addr, `DCS_ADDR_CFG);
    wire wr_srst = frame_hits(take, f_addr, `DCS_ADDR_SRST);
    wire rd_req = frame_hits(take, f_addr, `DCS_ADDR_READ);
    // Only the lowest data bit of the reset register acts.
    wire srst_go = wr_srst && f_data[`DCS_SRST_BIT];
    wire in_srst = (state_r == dcs_pkg::ST_SRST);

    // Software reset sequencer: fixed length, then back to running.
    // The count is loaded with one less than the length because the exit cycle counts too.
    // Frames that land during the sequence are dropped, not queued, so the host must wait.
    always_comb
    begin
        state_nxt = state_r;
        srst_cnt_nxt = srst_cnt_r;
        case (state_r)
            dcs_pkg::ST_RUN:
            begin
                if (srst_go)
                begin
                    state_nxt = dcs_pkg::ST_SRST;
                    srst_cnt_nxt = 8'(SRST_CYC - 1);
                end
            end
            dcs_pkg::ST_SRST:
            begin
                if (srst_cnt_r == 8'h00)
                    state_nxt = dcs_pkg::ST_RUN;
                else
                    srst_cnt_nxt = srst_cnt_r - 8'h01;
            end
            default:
            begin
                state_nxt = dcs_pkg::ST_RUN;
                srst_cnt_nxt = 8'h00;
            end
        endcase
    end

    // Sequencer state and countdown registers.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= dcs_pkg::ST_RUN;
            srst_cnt_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    // Request bit stands during the sequence and drops by itself at its end.
    // It is registered from the next state so it rises and falls with the sequencer.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            srst_req_r <= 1'b0;
        else
            srst_req_r <= (state_nxt == dcs_pkg::ST_SRST);
    end

    // Output code register, cleared by power-on and software reset.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            code_r <= `DCS_WORD_RST;
        else if (in_srst)
            code_r <= `DCS_WORD_RST;
        else if (wr_code)
            code_r <= fit_word(f_data);
    end

    // Gain trim word, unsigned.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            gain_r <= `DCS_WORD_RST;
        else if (in_srst)
            gain_r <= `DCS_WORD_RST;
        else if (wr_gain)
            gain_r <= fit_word(f_data);
    end

    // Zero trim word, two's complement.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            zero_r <= `DCS_WORD_RST;
        else if (in_srst)
            zero_r <= `DCS_WORD_RST;
        else if (wr_zero)
            zero_r <= fit_word(f_data);
    end

    // Configuration: trim enable, ramp enable and ramp selects.
    // Bits above the used fields are not stored and read back as zero.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_r <= '0;
        else if (in_srst)
            cfg_r <= '0;
        else if (wr_cfg)
            cfg_r <= f_data[`DCS_CFG_USED-1:0];
    end

    // Monitoring cycle tick, restarted by software reset.
    // A shorter cycle lets alarms drop sooner once their cause has gone.
    wire mon_tick = (mon_cnt_r == 16'(MON_CYC - 1));

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            mon_cnt_r <= 16'h0000;
        else if (in_srst || mon_tick)
            mon_cnt_r <= 16'h0000;
        else
            mon_cnt_r <= mon_cnt_r + 16'h0001;
    end

    // Alarm bits: set at once on detection, kept while set, and only
    // dropped at a monitoring tick that finds the cause gone, or during software reset. A cause still
    // present at the tick keeps the bit, so set wins over clear.
    wire [4:0] cause = mon_s2_r & 5'b11101;
    always_comb
    begin
        if (in_srst)
            alarm_nxt = 5'h00;
        else if (mon_tick)
            alarm_nxt = cause;
        else
            alarm_nxt = alarm_r | cause;
    end

    // Alarm register, cleared by power-on reset.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            alarm_r <= 5'h00;
        else
            alarm_r <= alarm_nxt;
    end

    // Status word assembly; the ramp bit follows its source directly.
    // The ramp bit is forced low during software reset, like the latched alarms.
    wire [15:0] status_word = {11'h000,
                               alarm_r[`DCS_ST_CRC],
                               alarm_r[`DCS_ST_WD],
                               alarm_r[`DCS_ST_LOAD],
                               mon_s2_r[`DCS_ST_RAMP] & ~in_srst,
                               alarm_r[`DCS_ST_TEMP]};

    // Readback selection; write-only and unmapped addresses return zero.
    // Words are copied at decode time, so a later change shows only on the next read.
    wire [7:0] rd_addr = f_data[7:0];
    always_comb
    begin
        rd_word_nxt = rd_word_r;
        if (in_srst)
            rd_word_nxt = `DCS_WORD_RST;
        else if (rd_req)
        begin
            case (rd_addr)
                `DCS_ADDR_CODE: rd_word_nxt = fit_word(code_r);
                `DCS_ADDR_GAIN: rd_word_nxt = fit_word(gain_r);
                `DCS_ADDR_ZERO: rd_word_nxt = fit_word(zero_r);
                `DCS_ADDR_CFG: rd_word_nxt = 16'(cfg_r);
                `DCS_ADDR_STAT: rd_word_nxt = status_word;
                default: rd_word_nxt = 16'h0000;
            endcase
        end
    end

    // Readback word, held stable across the following frame.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rd_word_r <= `DCS_WORD_RST;
        else
            rd_word_r <= rd_word_nxt;
    end

    // The word crosses to the link clock without a handshake; it only moves between frames,
    // so the frame gap keeps the shifter from ever seeing it change mid-frame.
    assign lnk.rd_word = rd_word_r;

    // Calibration path toward the converter.
    // The trimmed code follows a register write by one cycle; reads return the untrimmed word.
    dcs_trim #(
        .RES_BITS(RES_BITS)
    ) u_trim (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(cfg_r[`DCS_CFG_TRIM]),
        .code(code_r),
        .gain(gain_r),
        .zero(zero_r),
        .trimmed(current_output_code)
    );

    // Configuration fields driven out to the ramp engine and trim logic.
    // They come straight from flops, so downstream logic on this clock may use them as is.
    assign user_trim_enable = cfg_r[`DCS_CFG_TRIM];
    assign ramp_enable = cfg_r[`DCS_CFG_RAMP];
    assign ramp_rate_clock_select = cfg_r[`DCS_CFG_CLK_LSB +: 4];
    assign ramp_step_select = cfg_r[`DCS_CFG_STEP_LSB +: 3];
    assign soft_reset_busy = srst_req_r;
endmodule

// ==== design/dcs_regs.svh ====
// Purpose: Addresses, field positions, reset values and timing counts of the code/status register bank.
// Assumes: 24-bit serial frames, address byte first, data word after it.
// Notes: Definitions only.
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
`define DCS_ADDR_NOP 8'h00
`define DCS_ADDR_CODE 8'h01
`define DCS_ADDR_READ 8'h02
`define DCS_ADDR_CFG 8'h03
`define DCS_ADDR_GAIN 8'h04
`define DCS_ADDR_ZERO 8'h05
`define DCS_ADDR_STAT 8'h06
`define DCS_ADDR_SRST 8'h56
`define DCS_WORD_RST 16'h0000
`define DCS_SRST_BIT 0
`define DCS_ST_CRC 4
`define DCS_ST_WD 3
`define DCS_ST_LOAD 2
`define DCS_ST_RAMP 1
`define DCS_ST_TEMP 0
`define DCS_CFG_TRIM 0
`define DCS_CFG_RAMP 1
`define DCS_CFG_CLK_LSB 2
`define DCS_CFG_STEP_LSB 6
`define DCS_CFG_USED 9
`define DCS_FRAME_BITS 24
`define DCS_MCLK_MHZ 50
`define DCS_SRST_NS 80
`define DCS_SRST_CYC ((`DCS_SRST_NS * `DCS_MCLK_MHZ + 999) / 1000)
`define DCS_MON_NS 1000
`define DCS_MON_CYC ((`DCS_MON_NS * `DCS_MCLK_MHZ) / 1000)
`endif

// ==== design/dcs_pkg.sv ====
// Purpose: Types shared by the register bank modules.
// Assumes: Nothing beyond the register header.
// Notes: Numbers live in dcs_regs.svh.
package dcs_pkg;
    typedef enum logic [0:0] {ST_RUN, ST_SRST} dcs_state_t;
    typedef logic [15:0] dcs_word_t;
    typedef logic [7:0] dcs_addr_t;
endpackage

// ==== design/dcs_link_if.sv ====
// Purpose: Carries frames and the readback word between link logic and core.
// Assumes: Frame word is stable for a whole frame after its toggle moves.
// Notes: Toggle is the crossing event, words are quasi-static.
`timescale 1ns/1ps
interface dcs_link_if;
    logic [23:0] frame_word;
    logic frame_tgl;
    dcs_pkg::dcs_word_t rd_word;
    modport link (output frame_word, output frame_tgl, input rd_word);
    modport core (input frame_word, input frame_tgl, output rd_word);
endinterface

// ==== design/dcs_link.sv ====
// Purpose: Serial receiver and readback shifter on the host link clock.
// Assumes: Host holds frame_sel_n low for one frame, MSB first, samples sdo on falling sclk.
// Notes: The bit counter is cleared asynchronously while frame_sel_n is high.
`timescale 1ns/1ps
`include "dcs_regs.svh"
module dcs_link (
    input wire logic sclk,
    input wire logic rst_n,
    input wire logic frame_sel_n,
    input wire logic sdin,
    output logic sdo,
    dcs_link_if.link lnk
);
    logic [4:0] bit_cnt_r;
    logic [22:0] shift_r;
    logic sdo_r;
    logic [23:0] word_r;
    logic tgl_r;
    wire clr_n = rst_n & ~frame_sel_n;
    wire last_bit = (bit_cnt_r == 5'(`DCS_FRAME_BITS - 1));
    wire [23:0] out_word = {8'h00, lnk.rd_word};
    wire [4:0] out_idx = 5'(`DCS_FRAME_BITS - 2) - bit_cnt_r;

    // Counts and shifts bits within one frame; idle level restarts the frame.
    always_ff @(posedge sclk or negedge clr_n)
    begin
        if (!clr_n)
        begin
            bit_cnt_r <= 5'h00;
            shift_r <= 23'h000000;
            sdo_r <= 1'b0;
        end
        else
        begin
            bit_cnt_r <= last_bit ? 5'h00 : bit_cnt_r + 5'h01;
            shift_r <= {shift_r[21:0], sdin};
            sdo_r <= last_bit ? 1'b0 : out_word[out_idx];
        end
    end

    // Captures a complete frame and flips the toggle that the core watches.
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_r <= 24'h000000;
            tgl_r <= 1'b0;
        end
        else if (clr_n && last_bit)
        begin
            word_r <= {shift_r, sdin};
            tgl_r <= ~tgl_r;
        end
    end

    assign sdo = sdo_r;
    assign lnk.frame_word = word_r;
    assign lnk.frame_tgl = tgl_r;
endmodule

// ==== design/dcs_trim.sv ====
// Purpose: Applies gain and zero trim to the output code.
// Assumes: Gain is unsigned, zero is two's complement.
// Notes: Result is clamped to the code range and registered.
`timescale 1ns/1ps
module dcs_trim #(
    parameter int RES_BITS = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire dcs_pkg::dcs_word_t code,
    input wire dcs_pkg::dcs_word_t gain,
    input wire dcs_pkg::dcs_word_t zero,
    output dcs_pkg::dcs_word_t trimmed
);
    // Gain scales from unity (0) toward twice; zero offsets the scaled code.
    wire [32:0] prod = {17'h00000, code} * {1'b1, gain};
    wire signed [18:0] sum = $signed({2'b00, prod[32:16]}) + $signed({{3{zero[15]}}, zero});
    wire [15:0] clamped = sum[18] ? 16'h0000 : (|sum[17:16] ? 16'hffff : sum[15:0]);
    wire [15:0] low_mask = 16'hffff << (16 - RES_BITS);
    wire [15:0] result = enable ? (clamped & low_mask) : code;

    // Holds the code that drives the converter.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            trimmed <= 16'h0000;
        else
            trimmed <= result;
    end
endmodule

// ==== testbench/dcs_core_monitor.sv ====
// Purpose: Port checks of the code/status register bank.
// Assumes: One mclk domain; frames leave a gap of 16 mclk.
// Notes: Bound to dcs_core after the module.
`timescale 1ns/1ps
module dcs_core_monitor #(
    parameter int RES_BITS = 16,
    parameter int SRST_CYC = 4,
    parameter int MON_CYC = 50
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic frame_sel_n,
    input wire dcs_pkg::dcs_word_t current_output_code,
    input wire logic user_trim_enable,
    input wire logic ramp_enable,
    input wire logic [3:0] ramp_rate_clock_select,
    input wire logic [2:0] ramp_step_select,
    input wire logic soft_reset_busy
);
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    logic [3:0] busy_r;
    logic [1:0] por_r;
    wire [8:0] cfg = {ramp_step_select, ramp_rate_clock_select, ramp_enable, user_trim_enable};
    // Idle count saturates so long gaps stay distinguishable.
    assign idle_nxt = !frame_sel_n ? 4'h0 : ((idle_r == 4'hf) ? idle_r : idle_r + 4'h1);
    // Counts idle cycles, busy length and cycles since reset.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_r <= 4'h0;
            busy_r <= 4'h0;
            por_r <= 2'h0;
        end
        else
        begin
            idle_r <= idle_nxt;
            busy_r <= soft_reset_busy ? busy_r + 4'h1 : 4'h0;
            por_r <= (por_r == 2'h3) ? por_r : por_r + 2'h1;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    AST_SRST_LEN: assert property ($fell(soft_reset_busy) |-> busy_r == SRST_CYC)
        else $error("soft reset length wrong");
    AST_SRST_CFG: assert property ($fell(soft_reset_busy) |-> cfg == 9'h000)
        else $error("config not cleared by soft reset");
    AST_SRST_CODE: assert property ($fell(soft_reset_busy) |-> ##2 current_output_code == 16'h0000)
        else $error("code not cleared by soft reset");
    AST_SRST_SRC: assert property ($rose(soft_reset_busy) |-> idle_r >= 4'h1 && idle_r <= 4'h8)
        else $error("soft reset without a frame");
    AST_SRST_DONE: assert property (idle_r == 4'hf |-> !soft_reset_busy)
        else $error("soft reset bit stuck");
    AST_IDLE_HOLD: assert property (idle_r >= 4'hd |-> $stable(current_output_code) && $stable(cfg))
        else $error("outputs moved while link idle");
    AST_CODE_LAG: assert property ($changed(current_output_code) |-> idle_r inside {[1:11]})
        else $error("code changed away from a frame");
    AST_POR: assert property (por_r < 2'h2 |-> current_output_code == 16'h0000 && cfg == 9'h000)
        else $error("outputs not zero after reset");
endmodule
bind dcs_core dcs_core_monitor #(.RES_BITS(RES_BITS), .SRST_CYC(SRST_CYC), .MON_CYC(MON_CYC)) mon (
    .mclk(mclk),
    .rst_n(rst_n),
    .frame_sel_n(frame_sel_n),
    .current_output_code(current_output_code),
    .user_trim_enable(user_trim_enable),
    .ramp_enable(ramp_enable),
    .ramp_rate_clock_select(ramp_rate_clock_select),
    .ramp_step_select(ramp_step_select),
    .soft_reset_busy(soft_reset_busy)
);

// ==== testbench/dcs_host.sv ====
// Purpose: Host side of the serial link.
// Assumes: 32 ns link clock, MSB first, sdo sampled on falling sclk.
// Notes: sclk stands low between frames; sdin flips when released.
`timescale 1ns/1ps
module dcs_host (
    output logic sclk,
    output logic frame_sel_n,
    output logic sdin,
    input wire logic sdo
);
    initial
    begin
        sclk = 1'b0;
        frame_sel_n = 1'b1;
        sdin = 1'b0;
    end
    // Sends one address byte and one word, collects the 16 sdo bits after sclk 8 to 23, not the 24th.
    task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        logic [23:0] w;
        int n;
        w = {a, d};
        q = 16'h0000;
        #7 frame_sel_n = 1'b0;
        for (n = 1; n <= 24; n++)
        begin
            sdin = w[24 - n];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
            if (n >= 8 && n <= 23)
                q = {q[14:0], sdo};
        end
        #16 frame_sel_n = 1'b1;
        sdin = ~sdin;
    endtask
endmodule

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench of the code/status register bank.
// Assumes: Host model frames the link; other inputs move on falling mclk.
// Notes: Monitor period is shortened so alarm clears come quickly.
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic [7:0] wa;
        logic [15:0] wd;
        logic [7:0] ra;
        logic [15:0] ex;
    } dcs_row_t;
    localparam int MON = 8;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] src = 5'h00;
    wire logic sclk, frame_sel_n, sdin, sdo, trim_o, ramp_o, busy_o;
    wire logic [3:0] rate_o;
    wire logic [2:0] step_o;
    dcs_pkg::dcs_word_t code_o;
    wire [15:0] cfg_o = {7'h00, step_o, rate_o, ramp_o, trim_o};
    int miscompares = 0;
    int checks_done = 0;
    int busy_cnt = 0;
    dcs_row_t rows [6] = '{'{8'h01, 16'ha5c3, 8'h01, 16'ha5c3}, '{8'h04, 16'hffff, 8'h04, 16'hffff},
        '{8'h05, 16'h8001, 8'h05, 16'h8001}, '{8'h06, 16'h001f, 8'h06, 16'h0000},
        '{8'h56, 16'hfffe, 8'h01, 16'ha5c3}, '{8'h00, 16'h1234, 8'h56, 16'h0000}};
    logic [15:0] tc [5][3] = '{'{16'h8000, 16'h0000, 16'h0010}, '{16'h8000, 16'h8000, 16'hfff0},
        '{16'hffff, 16'h0000, 16'h0010}, '{16'hffff, 16'hffff, 16'h0000}, '{16'h0010, 16'h0000, 16'hffe0}};
    logic [7:0] ra [4] = '{8'h01, 8'h04, 8'h05, 8'h06};
    dcs_core #(.RES_BITS(16), .SRST_CYC(4), .MON_CYC(MON)) uut (
        .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .frame_sel_n(frame_sel_n), .sdin(sdin), .sdo(sdo),
        .frame_check_src(src[4]), .timeout_src(src[3]), .output_load_src(src[2]),
        .ramp_active_src(src[1]), .overtemp_src(src[0]), .current_output_code(code_o),
        .user_trim_enable(trim_o), .ramp_enable(ramp_o), .ramp_rate_clock_select(rate_o),
        .ramp_step_select(step_o), .soft_reset_busy(busy_o));
    dcs_host host (.sclk(sclk), .frame_sel_n(frame_sel_n), .sdin(sdin), .sdo(sdo));
    always #10 mclk = ~mclk;
    // Counts cycles spent in software reset, sampled away from the edge that moves the flag.
    always @(negedge mclk)
        if (busy_o === 1'b1)
            busy_cnt++;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic gap();
        repeat (16) @(negedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.xfer(a, d, q);
        gap();
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] q);
        wr(8'h02, {8'h00, a});
        host.xfer(8'h00, 16'h0000, q);
        gap();
    endtask
    // Gain is unsigned with zero as unity, zero trim is signed, result clamped.
    function automatic logic [15:0] trim_exp(logic [15:0] c, logic [15:0] g, logic [15:0] z);
        logic [33:0] p;
        logic signed [20:0] s;
        p = {18'h0, c} * ({18'h0, g} + 34'h10000);
        s = $signed({3'h0, p[33:16]}) + $signed({{5{z[15]}}, z});
        return (s < 0) ? 16'h0000 : ((s > 21'sh00ffff) ? 16'hffff : s[15:0]);
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #2000000;
        miscompares++;
        stop_test();
    end
    // Reset values, register rows, trim, software reset and alarms.
    initial
    begin
        logic [15:0] q;
        int i;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        gap();
        chk(cfg_o, 16'h0000, "cfg after reset");
        for (i = 0; i < 4; i++)
        begin
            rd(ra[i], q);
            chk(q, 16'h0000, "reset value");
        end
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, q);
            chk(q, rows[i].ex, "readback");
        end
        wr(8'h03, 16'h0001);
        for (i = 0; i < 5; i++)
        begin
            wr(8'h01, tc[i][0]);
            wr(8'h04, tc[i][1]);
            wr(8'h05, tc[i][2]);
            chk(code_o, trim_exp(tc[i][0], tc[i][1], tc[i][2]), "trimmed code");
        end
        wr(8'h03, 16'h01fe);
        chk(cfg_o, 16'h01fe, "cfg outputs");
        chk(code_o, tc[4][0], "raw code");
        busy_cnt = 0;
        wr(8'h56, 16'h0001);
        chk(16'(busy_cnt), 16'h0004, "reset length");
        chk(cfg_o, 16'h0000, "cfg after soft reset");
        chk(code_o, 16'h0000, "code after soft reset");
        rd(8'h04, q);
        chk(q, 16'h0000, "gain after soft reset");
        for (i = 0; i < 5; i++)
        begin
            src = 5'h01 << i;
            rd(8'h06, q);
            chk(q, 16'h0001 << i, "status bit");
        end
        src = 5'h00;
        repeat (3 * MON) @(negedge mclk);
        rd(8'h06, q);
        chk(q, 16'h0000, "status cleared");
        src = 5'h04;
        wr(8'h56, 16'h0001);
        rd(8'h06, q);
        chk(q, 16'h0004, "alarm after soft reset");
        src = 5'h00;
        stop_test();
    end
endmodule
